// File: dv/spi_byte_sva.sv
// Checker for the byte-wide serial unit, watching only its top ports.
// Assumes one clock domain, sys_clk, with nrst as asynchronous reset.
`timescale 1ns/1ps
module spi_byte_sva (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Link and events
	input wire logic spi_ss_n,
	input wire logic spi_miso_oe,
	input wire logic tx_empty_evt,
	input wire logic xfer_done_evt
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
	AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	AST_W_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
	// Select must be settled through the synchroniser before the pin is released
	AST_OE_IDLE: assert property (spi_ss_n [*6] |-> !spi_miso_oe)
		else $error("miso driven while deselected");
	AST_DONE_PULSE: assert property (xfer_done_evt |=> !xfer_done_evt)
		else $error("done event longer than one cycle");
	AST_TXE_PULSE: assert property (tx_empty_evt |=> !tx_empty_evt)
		else $error("tx empty event longer than one cycle");
	AST_DONE_SEL: assert property (xfer_done_evt |-> !spi_ss_n && spi_miso_oe)
		else $error("done outside a selected frame");
	AST_TXE_SEL: assert property (tx_empty_evt |-> !$past(spi_ss_n, 2))
		else $error("tx empty event without frame start");
endmodule
bind spi_byte_shifter_regs spi_byte_sva u_sva (.sys_clk(sys_clk), .nrst(nrst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .spi_ss_n(spi_ss_n), .spi_miso_oe(spi_miso_oe),
	.tx_empty_evt(tx_empty_evt), .xfer_done_evt(xfer_done_evt));

// File: dv/spi_partner.sv
// Link master model on the far side of the serial unit, 80 ns clock.
// Assumes the bench changes mode only between frames.
`timescale 1ns/1ps
module spi_partner (
	// Link
	output logic spi_sclk,
	output logic spi_ss_n,
	output logic spi_mosi,
	input wire logic spi_miso_o
);
	logic cpol = 1'b0;
	logic cpha = 1'b0;
	logic lsb = 1'b0;
	initial begin
		spi_sclk = 1'b0;
		spi_ss_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// Clock stands still outside frames; released data line shows the inverse
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int k;
		spi_sclk = cpol;
		#40;
		spi_ss_n = 1'b0;
		#80;
		for (int i = 0; i < 8; i++) begin
			k = lsb ? i : 7 - i;
			if (!cpha) spi_mosi = tx[k];
			#40;
			if (!cpha) rx[k] = spi_miso_o;
			spi_sclk = ~cpol;
			if (cpha) spi_mosi = tx[k];
			#40;
			if (cpha) rx[k] = spi_miso_o;
			spi_sclk = cpol;
		end
		#120;
		spi_ss_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#200;
	endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the byte-wide serial unit and its registers.
// Assumes the partner model drives the link; bench drives the register bus.
`timescale 1ns/1ps
module testbench;
	import spi_byte_pkg::*;
	logic sys_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid, sclk, ss_n, mosi, miso, oe, txe, done;
	logic [1:0] bresp, rresp;
	logic [15:0] lfsr_q;
	logic miso_line;
	localparam logic [11:0] TX_ADDR = 12'(ADDR_TX_BYTE);
	localparam logic [11:0] RX_ADDR = 12'(ADDR_RX_BYTE);
	localparam logic [11:0] CSR_ADDR = 12'(ADDR_CTRL_STAT);
	int fails = 0, total_checks = 0, txe_n = 0, done_n = 0;
	spi_byte_shifter_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .spi_sclk(sclk), .spi_ss_n(ss_n), .spi_mosi(mosi),
		.spi_miso_o(miso), .spi_miso_oe(oe), .tx_empty_evt(txe), .xfer_done_evt(done));
	// A released data line shows the inverse of its last bit, so early sampling shows up
	assign miso_line = oe ? miso : ~miso;
	spi_partner p (.spi_sclk(sclk), .spi_ss_n(ss_n), .spi_mosi(mosi), .spi_miso_o(miso_line));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] csr(input logic [7:0] c, input logic [3:0] f);
		return {24'h000000, c[7], f, c[2:0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk(32'(got), 32'(exp));
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		chk(32'(got), 32'(exp));
	endtask
	task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
		chk(got, exp);
	endtask
	// Readies are looked at on the falling edge so the taking edge is never raced
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Some answers are left waiting a cycle so that they must stand
		bready <= !lfsr_q[0];
		fork
			begin
				do @(negedge sys_clk); while (awready !== 1'b1);
				@(posedge sys_clk);
				awvalid <= 1'b0;
			end
			begin
				do @(negedge sys_clk); while (wready !== 1'b1);
				@(posedge sys_clk);
				wvalid <= 1'b0;
			end
		join
		do @(negedge sys_clk); while (bvalid !== 1'b1);
		r = bresp;
		if (!bready) begin
			@(posedge sys_clk);
			bready <= 1'b1;
		end
		@(posedge sys_clk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !lfsr_q[1];
		do @(negedge sys_clk); while (arready !== 1'b1);
		@(posedge sys_clk);
		arvalid <= 1'b0;
		do @(negedge sys_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		if (!rready) begin
			@(posedge sys_clk);
			rready <= 1'b1;
		end
		@(posedge sys_clk);
		rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk_resp(r, RESP_OKAY);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ------------------------------------------------------------------
	// Clock, watchdog, event counting and main sequence
	// ------------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		#200000;
		fails++;
		give_verdict();
	end
	always @(posedge sys_clk) begin
		if (txe === 1'b1) txe_n++;
		if (done === 1'b1) done_n++;
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] cfg, tb0, mb0, mb1, got;
		{nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		lfsr_q = 16'hA0F9;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		rdchk(TX_ADDR, 32'h00000000);
		rdchk(RX_ADDR, 32'h00000000);
		rdchk(CSR_ADDR, csr(8'h00, 4'h2));
		rd(12'h0A0, d, r);
		chk_resp(r, RESP_SLVERR);
		wr(12'hFFC, 8'h5A, r);
		chk_resp(r, RESP_SLVERR);
		wr(RX_ADDR, 8'hA5, r);
		chk_resp(r, RESP_OKAY);
		rdchk(RX_ADDR, 32'h00000000);
		// With the low byte lane off the write must not enable the unit
		wstrb <= 4'hE;
		wr(CSR_ADDR, 8'h01, r);
		wstrb <= 4'hF;
		rdchk(CSR_ADDR, csr(8'h00, 4'h2));
		wr(TX_ADDR, 8'h3C, r);
		p.xfer(8'h81, got);
		rdchk(CSR_ADDR, csr(8'h00, 4'h2));
		for (int m = 0; m < 8; m++) begin
			cfg = {m[2], 4'h0, m[1], m[0], 1'b1};
			wr(CSR_ADDR, 8'h00, r);
			p.cpol = m[0];
			p.cpha = m[1];
			p.lsb = m[2];
			wr(CSR_ADDR, cfg, r);
			lfsr_q = lfsr(lfsr_q);
			{mb0, tb0} = lfsr_q;
			lfsr_q = lfsr(lfsr_q);
			mb1 = lfsr_q[7:0];
			wr(TX_ADDR, tb0, r);
			rdchk(CSR_ADDR, csr(cfg, 4'h0));
			p.xfer(mb0, got);
			chk_byte(got, tb0);
			p.xfer(mb1, got);
			chk_byte(got, 8'h00);
			rdchk(CSR_ADDR, csr(cfg, 4'hF));
			rdchk(CSR_ADDR, csr(cfg, 4'h3));
			rdchk(RX_ADDR, 32'(mb1));
			rdchk(CSR_ADDR, csr(cfg, 4'h2));
		end
		chk_count(txe_n, 32'd8);
		chk_count(done_n, 32'd16);
		give_verdict();
	end
endmodule

// File: hw/spi_bit_engine.sv
// Eight-bit shift engine: sends one byte and assembles one byte per transfer.
// Assumes lead and trail are one-cycle pulses from a synchronised serial clock.
`timescale 1ns/1ps
module spi_bit_engine (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Control
	input wire logic active,
	input wire logic load,
	input wire logic [7:0] load_byte,
	input wire logic lsb_first,
	input wire logic phase,
	// Link events
	input wire logic lead,
	input wire logic trail,
	input wire logic mosi,
	// Results
	output logic miso_q,
	output logic [7:0] rx_byte_q,
	output logic done_q
);
	import spi_byte_pkg::*;

	logic [7:0] sh_q, sh_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] rx_byte_d;
	logic [3:0] cnt_m1;
	logic [2:0] idx;
	logic sample;
	logic miso_d;
	logic done_d;

	// ------------------------------------------------------------------
	// Edge counting and bit assembly
	// ------------------------------------------------------------------
	always_comb begin
		sh_d = sh_q;
		rx_sh_d = rx_sh_q;
		cnt_d = cnt_q;
		rx_byte_d = rx_byte_q;
		done_d = 1'b0;
		sample = phase ? trail : lead; // R12
		if (load) begin
			sh_d = load_byte; // R15
			cnt_d = '0;
		end else if (!active) begin
			cnt_d = '0;
		end else if (lead || trail) begin
			if (sample) begin
				rx_sh_d = lsb_first ? {mosi, rx_sh_q[7:1]} : {rx_sh_q[6:0], mosi}; // R04
			end
			// Sixteen edges close a byte, so the final clock is always seen
			if (cnt_q == EDGE_LAST) begin
				cnt_d = '0;
				done_d = 1'b1; // R08
				rx_byte_d = rx_sh_d; // R15
			end else begin
				cnt_d = cnt_q + 4'h1;
			end
		end
		cnt_m1 = cnt_d - 4'h1;
		// Phase one holds the first bit until the second leading edge
		if (phase) begin
			idx = (cnt_d == 4'h0) ? 3'h0 : cnt_m1[3:1]; // R12
		end else begin
			idx = cnt_d[3:1]; // R12
		end
		miso_d = lsb_first ? sh_d[idx] : sh_d[3'h7 - idx]; // R04
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sh_q <= RST_BYTE;
			rx_sh_q <= RST_BYTE;
			cnt_q <= '0;
			rx_byte_q <= RST_BYTE;
			done_q <= 1'b0;
			miso_q <= 1'b0;
		end else begin
			sh_q <= sh_d;
			rx_sh_q <= rx_sh_d;
			cnt_q <= cnt_d;
			rx_byte_q <= rx_byte_d;
			done_q <= done_d;
			miso_q <= miso_d;
		end
	end

endmodule

// File: hw/spi_byte_pkg.sv
// Constants, register map and state codes for the byte-wide serial unit.
// Assumes a 32-bit AXI4-Lite register bus and a sampled serial link.
package spi_byte_pkg;

	// ------------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_TX_BYTE = 8'h29;
	localparam logic [7:0] IDX_RX_BYTE = 8'h2A;
	localparam logic [7:0] IDX_CTRL_STAT = 8'h2B;
	localparam logic [9:0] ADDR_TX_BYTE = {IDX_TX_BYTE, 2'h0};
	localparam logic [9:0] ADDR_RX_BYTE = {IDX_RX_BYTE, 2'h0};
	localparam logic [9:0] ADDR_CTRL_STAT = {IDX_CTRL_STAT, 2'h0};
	localparam int MIN_ADDR_W = 10;

	// ------------------------------------------------------------------
	// Control and status field positions
	// ------------------------------------------------------------------
	localparam int BIT_LSB_FIRST = 7;
	localparam int BIT_OVERRUN = 6;
	localparam int BIT_COMPLETE = 5;
	localparam int BIT_TX_EMPTY = 4;
	localparam int BIT_RX_FULL = 3;
	localparam int BIT_PHASE = 2;
	localparam int BIT_POLARITY = 1;
	localparam int BIT_ENABLE = 0;

	// ------------------------------------------------------------------
	// Reset values and link constants
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_TX_EMPTY = 1'b1;
	localparam int BYTE_W = 8;
	localparam logic [3:0] EDGE_LAST = 4'hF;
	localparam logic [2:0] SYNC_RST = 3'h2;

	// ------------------------------------------------------------------
	// Bus responses and register selects
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SEL_NONE = 2'h0,
		SEL_TX = 2'h1,
		SEL_RX = 2'h2,
		SEL_CSR = 2'h3
	} reg_sel_t;

	typedef enum logic [2:0] {
		ST_OFF = 3'h1,
		ST_IDLE = 3'h2,
		ST_BUSY = 3'h4
	} link_state_t;

endpackage

// File: hw/spi_byte_shifter_regs.sv
// Byte-wide serial unit behind an AXI4-Lite register slave (link slave side).
// Assumes the partner drives serial clock and select; both are sampled here.
//
// How it works
// R01: Write-only transmit byte register, reset zero
// R02: Read-only receive byte register, reset zero
// R03: Control/status register mixes config and flags
// R04: Bit seven chooses LSB-first, else MSB-first
// R05: Software keeps config steady while enabled
// R06: Config and enable accepted in one write
// R07: Overrun sets on unread byte; CSR read clears
// R08: Complete sets after full byte; CSR read clears
// R09: TX empty one at reset/disabled; write clears
// R10: TX empty event only after byte enters shifter
// R11: RX full sets on load; RX read clears
// R12: Phase picks sample and change clock edges
// R13: Polarity sets serial clock idle level
// R14: Enable bit switches the whole function
// R15: Each transfer shifts exactly eight bits both ways
`timescale 1ns/1ps
module spi_byte_shifter_regs #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial link
	input wire logic spi_sclk,
	input wire logic spi_ss_n,
	input wire logic spi_mosi,
	output logic spi_miso_o,
	output logic spi_miso_oe,
	// Events
	output logic tx_empty_evt,
	output logic xfer_done_evt
);
	import spi_byte_pkg::*;

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (ADDR_W < MIN_ADDR_W || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must lie between 10 and 32");
	end

	// ------------------------------------------------------------------
	// Address decode, shared by the write and read paths
	// ------------------------------------------------------------------
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		if (a == ADDR_W'(ADDR_TX_BYTE)) begin
			s = SEL_TX;
		end else if (a == ADDR_W'(ADDR_RX_BYTE)) begin
			s = SEL_RX;
		end else if (a == ADDR_W'(ADDR_CTRL_STAT)) begin
			s = SEL_CSR;
		end
		return s;
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_d;
	logic wstrb0_q, wstrb0_d, aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic do_wr, rd_fire;
	reg_sel_t wr_sel, rd_sel;
	logic [7:0] tx_buf_q, tx_buf_d, rx_buf_q, rx_buf_d, csr_val;
	logic tx_empty_q, tx_empty_d, rx_full_q, rx_full_d, ovr_q, ovr_d, cmp_q, cmp_d;
	logic lsb_q, lsb_d, cpha_q, cpha_d, cpol_q, cpol_d, en_q, en_d;
	link_state_t st_q, st_d;
	logic ss_prev_q, sclk_prev_q, miso_oe_d, tx_evt_d;
	logic sclk_s, ss_n_s, mosi_s, rise, fall, lead, trail, ss_fall;
	logic load, active, eng_miso, eng_done;
	logic [7:0] load_byte, eng_rx;

	// ------------------------------------------------------------------
	// Link input synchronisation
	// ------------------------------------------------------------------
	sync_2ff #(
		.WIDTH(3),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in({spi_sclk, spi_ss_n, spi_mosi}),
		.sync_out({sclk_s, ss_n_s, mosi_s})
	);

	assign rise = sclk_s && !sclk_prev_q;
	assign fall = !sclk_s && sclk_prev_q;
	assign lead = cpol_q ? fall : rise; // R13
	assign trail = cpol_q ? rise : fall; // R13
	assign ss_fall = ss_prev_q && !ss_n_s;

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
	assign wr_sel = decode(awaddr_q);

	always_comb begin
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb0_d = wstrb0_q;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_d = s_axi_awaddr;
			aw_got_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_d = s_axi_wdata;
			wstrb0_d = s_axi_wstrb[0];
			w_got_d = 1'b1;
		end
		if (do_wr) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		awready_d = !aw_got_d && !bvalid_d;
		wready_d = !w_got_d && !bvalid_d;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb0_q <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb0_q <= wstrb0_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path; read side effects act on the address handshake
	// ------------------------------------------------------------------
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_sel = decode(s_axi_araddr);
	assign csr_val = {lsb_q, ovr_q, cmp_q, tx_empty_q, rx_full_q, cpha_q, cpol_q, en_q}; // R03

	always_comb begin
		rvalid_d = s_axi_rvalid;
		rdata_d = s_axi_rdata;
		rresp_d = s_axi_rresp;
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = '0;
			case (rd_sel)
				SEL_RX: rdata_d = {24'h000000, rx_buf_q}; // R02
				SEL_CSR: rdata_d = {24'h000000, csr_val}; // R03
				SEL_TX: rdata_d = '0; // R01
				default: rresp_d = RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_rvalid <= rvalid_d;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
			s_axi_arready <= arready_d;
		end
	end

	// ------------------------------------------------------------------
	// Transfer sequencing
	// ------------------------------------------------------------------
	// A new byte starts on select falling, or straight after a byte while
	// select stays low; an empty buffer sends zeros rather than stalling.
	always_comb begin
		st_d = st_q;
		load = 1'b0;
		case (st_q)
			ST_OFF: begin
				if (en_q) begin
					st_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (ss_fall) begin
					load = 1'b1;
					st_d = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (ss_n_s) begin
					st_d = ST_IDLE;
				end else if (eng_done) begin
					load = 1'b1;
				end
			end
			default: st_d = ST_OFF;
		endcase
		if (!en_q) begin
			st_d = ST_OFF; // R14
			load = 1'b0;
		end
		load_byte = tx_empty_q ? RST_BYTE : tx_buf_q;
		active = (st_q == ST_BUSY) && !ss_n_s && en_q; // R14
	end

	spi_bit_engine u_engine (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.active(active),
		.load(load),
		.load_byte(load_byte),
		.lsb_first(lsb_q),
		.phase(cpha_q),
		.lead(lead),
		.trail(trail),
		.mosi(mosi_s),
		.miso_q(eng_miso),
		.rx_byte_q(eng_rx),
		.done_q(eng_done)
	);

	// ------------------------------------------------------------------
	// Registers and flags; a set wins over a same-cycle clear, except that a TX write beats a load on TX empty
	// ------------------------------------------------------------------
	always_comb begin
		tx_buf_d = tx_buf_q;
		tx_empty_d = tx_empty_q;
		rx_buf_d = rx_buf_q;
		rx_full_d = rx_full_q;
		ovr_d = ovr_q;
		cmp_d = cmp_q;
		lsb_d = lsb_q;
		cpha_d = cpha_q;
		cpol_d = cpol_q;
		en_d = en_q;
		tx_evt_d = load && !tx_empty_q; // R10
		if (load) begin
			tx_empty_d = 1'b1; // R10
		end
		if (do_wr && wstrb0_q && wr_sel == SEL_TX) begin
			tx_buf_d = wdata_q[7:0]; // R01
			tx_empty_d = 1'b0; // R09
		end
		if (do_wr && wstrb0_q && wr_sel == SEL_CSR) begin
			// Config and enable land together in one write
			lsb_d = wdata_q[BIT_LSB_FIRST]; // R06
			cpha_d = wdata_q[BIT_PHASE]; // R06
			cpol_d = wdata_q[BIT_POLARITY]; // R06
			en_d = wdata_q[BIT_ENABLE]; // R14
		end
		if (rd_fire && rd_sel == SEL_CSR) begin
			ovr_d = 1'b0; // R07
			cmp_d = 1'b0; // R08
		end
		if (rd_fire && rd_sel == SEL_RX) begin
			rx_full_d = 1'b0; // R11
		end
		if (eng_done && active) begin
			rx_buf_d = eng_rx; // R02
			rx_full_d = 1'b1; // R11
			cmp_d = 1'b1; // R08
			if (rx_full_q && !(rd_fire && rd_sel == SEL_RX)) begin
				ovr_d = 1'b1; // R07
			end
		end
		if (!en_q) begin
			tx_empty_d = 1'b1; // R09
		end
		miso_oe_d = en_q && !ss_n_s;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tx_buf_q <= RST_BYTE;
			tx_empty_q <= RST_TX_EMPTY;
			rx_buf_q <= RST_BYTE;
			rx_full_q <= 1'b0;
			ovr_q <= 1'b0;
			cmp_q <= 1'b0;
			lsb_q <= 1'b0;
			cpha_q <= 1'b0;
			cpol_q <= 1'b0;
			en_q <= 1'b0;
			st_q <= ST_OFF;
			ss_prev_q <= 1'b1;
			sclk_prev_q <= 1'b0;
			spi_miso_oe <= 1'b0;
			tx_empty_evt <= 1'b0;
			xfer_done_evt <= 1'b0;
		end else begin
			tx_buf_q <= tx_buf_d;
			tx_empty_q <= tx_empty_d;
			rx_buf_q <= rx_buf_d;
			rx_full_q <= rx_full_d;
			ovr_q <= ovr_d;
			cmp_q <= cmp_d;
			lsb_q <= lsb_d;
			cpha_q <= cpha_d;
			cpol_q <= cpol_d;
			en_q <= en_d;
			st_q <= st_d;
			ss_prev_q <= ss_n_s;
			sclk_prev_q <= sclk_s;
			spi_miso_oe <= miso_oe_d;
			tx_empty_evt <= tx_evt_d;
			xfer_done_evt <= eng_done && active;
		end
	end

	// Engine output is already a flop; no extra stage keeps setup margin
	assign spi_miso_o = eng_miso;

endmodule

// File: hw/sync_2ff.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps
module sync_2ff #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule
